// File: rtl/ebt_pkg.sv
package ebt_pkg;
   localparam logic [3:0] OFS_CTRL_A   = 4'h0;
   localparam logic [3:0] OFS_CTRL_B   = 4'h4;
   localparam logic [3:0] OFS_COUNT    = 4'h8;
   localparam logic [3:0] OFS_MATCH_A  = 4'hc;
   localparam logic [4:0] OFS_MATCH_B  = 5'h18;
   localparam logic [4:0] OFS_PORT     = 5'h10;
   localparam logic [4:0] OFS_FLAGS    = 5'h14;
   localparam logic [7:0] CTRL_A_MASK  = 8'hf3;
   localparam logic [7:0] CTRL_B_MASK  = 8'h0f;
   localparam logic [7:0] VAL_MAX      = 8'hff;
   localparam logic [7:0] VAL_BOTTOM   = 8'h00;
   localparam logic [9:0] DIV_8        = 10'h007;
   localparam logic [9:0] DIV_32       = 10'h01f;
   localparam logic [9:0] DIV_64       = 10'h03f;
   localparam logic [9:0] DIV_128      = 10'h07f;
   localparam logic [9:0] DIV_256      = 10'h0ff;
   localparam logic [9:0] DIV_1024     = 10'h3ff;
   typedef enum logic [2:0]
   {
      EBT_NORMAL  = 3'b000,
      EBT_PC_FF   = 3'b001,
      EBT_CTC     = 3'b010,
      EBT_FAST_FF = 3'b011,
      EBT_RES4    = 3'b100,
      EBT_PC_A    = 3'b101,
      EBT_RES6    = 3'b110,
      EBT_FAST_A  = 3'b111
   } ebt_mode_e;
   typedef enum logic [1:0]
   {
      ACT_OFF = 2'b00,
      ACT_TGL = 2'b01,
      ACT_CLR = 2'b10,
      ACT_SET = 2'b11
   } ebt_act_e;
endpackage

// File: rtl/ebt_timer.sv
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ebt_timer
   import ebt_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic        CLK_EN,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             CHAN_A_WAVE_PIN_O,
   output logic             CHAN_A_WAVE_PIN_OE_N,
   output logic             CHAN_B_WAVE_PIN_O,
   output logic             CHAN_B_WAVE_PIN_OE_N,
   output logic             MATCH_A_EVENT,
   output logic             MATCH_B_EVENT,
   output logic             OVERFLOW_EVENT
);
   import ebt_pkg::*;

   logic        rst_s1_r;
   logic        rst_s2_r;
   logic        rst_n;
   logic [7:0]  ctrl_a_r;
   logic [7:0]  ctrl_b_r;
   logic [7:0]  count_r;
   logic [7:0]  match_a_r;
   logic [7:0]  match_b_r;
   logic [7:0]  buf_a_r;
   logic [7:0]  buf_b_r;
   logic [3:0]  port_r;
   logic        up_r;
   logic        block_r;
   logic        wave_a_r;
   logic        wave_b_r;
   logic        ev_a_r;
   logic        ev_b_r;
   logic        ev_ov_r;
   logic        rd_done_r;
   logic [9:0]  pre_r;
   logic        tick;
   logic        wr;
   logic [2:0]  mode;
   logic        pwm;
   logic        fast;
   logic        pcor;
   logic [7:0]  top;
   logic        at_top;
   logic        hit_a;
   logic        hit_b;
   logic        force_a;
   logic        force_b;
   logic        cnt_wr;
   logic [1:0]  act_a;
   logic [1:0]  act_b;
   logic        conn_a;

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rst_n = rst_s2_r;

   function automatic logic sel(input logic [4:0] adr, input logic [4:0] ofs);
      sel = (adr == ofs);
   endfunction

   assign wr      = AVS_WRITE && CLK_EN && AVS_BYTEENABLE[0];
   assign act_a   = ctrl_a_r[7:6];
   assign act_b   = ctrl_a_r[5:4];
   // channel A action 01 in pwm with top bit clear leaves the pin to the port
   assign conn_a  = (act_a != ACT_OFF) && !(pwm && act_a == ACT_TGL && !mode[2]);
   assign mode    = {ctrl_b_r[3], ctrl_a_r[1:0]};
   assign fast    = (mode == EBT_FAST_FF) || (mode == EBT_FAST_A);
   assign pcor    = (mode == EBT_PC_FF) || (mode == EBT_PC_A);
   assign pwm     = fast || pcor;
   assign top     = (mode == EBT_CTC || mode == EBT_PC_A || mode == EBT_FAST_A)
                    ? match_a_r : VAL_MAX;
   assign at_top  = (count_r == top);
   assign cnt_wr  = wr && sel(AVS_ADDRESS, {1'b0, OFS_COUNT});
   assign force_a = wr && sel(AVS_ADDRESS, {1'b0, OFS_CTRL_B})
                    && AVS_WRITEDATA[7] && !pwm;
   assign force_b = wr && sel(AVS_ADDRESS, {1'b0, OFS_CTRL_B})
                    && AVS_WRITEDATA[6] && !pwm;
   // compare disabled the tick after a counter write
   assign hit_a   = tick && !block_r && (count_r == match_a_r);
   assign hit_b   = tick && !block_r && (count_r == match_b_r);

   // prescaler taps
   always_comb
   begin
      case (ctrl_b_r[2:0])
         3'h1:    tick = 1'b1;
         3'h2:    tick = (pre_r[2:0] == DIV_8[2:0]);
         3'h3:    tick = (pre_r[4:0] == DIV_32[4:0]);
         3'h4:    tick = (pre_r[5:0] == DIV_64[5:0]);
         3'h5:    tick = (pre_r[6:0] == DIV_128[6:0]);
         3'h6:    tick = (pre_r[7:0] == DIV_256[7:0]);
         3'h7:    tick = (pre_r == DIV_1024);
         default: tick = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
         pre_r <= 10'h000;
      else if (CLK_EN)
         pre_r <= (ctrl_b_r[2:0] == 3'h0) ? 10'h000 : pre_r + 10'h001;
   end

   // register writes
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_a_r <= 8'h00;
         ctrl_b_r <= 8'h00;
         buf_a_r  <= 8'h00;
         buf_b_r  <= 8'h00;
         port_r   <= 4'h0;
      end
      else if (wr)
      begin
         if (sel(AVS_ADDRESS, {1'b0, OFS_CTRL_A}))
            ctrl_a_r <= AVS_WRITEDATA[7:0] & CTRL_A_MASK;
         if (sel(AVS_ADDRESS, {1'b0, OFS_CTRL_B}))
            ctrl_b_r <= AVS_WRITEDATA[7:0] & CTRL_B_MASK;
         if (sel(AVS_ADDRESS, {1'b0, OFS_MATCH_A}))
            buf_a_r <= AVS_WRITEDATA[7:0];
         if (sel(AVS_ADDRESS, OFS_MATCH_B))
            buf_b_r <= AVS_WRITEDATA[7:0];
         if (sel(AVS_ADDRESS, OFS_PORT))
            port_r <= AVS_WRITEDATA[3:0];
      end
   end

   // compare buffers: immediate in non-PWM, at TOP in PWM
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         match_a_r <= 8'h00;
         match_b_r <= 8'h00;
      end
      else if (CLK_EN && (!pwm || (tick && at_top)))
      begin
         match_a_r <= buf_a_r;
         match_b_r <= buf_b_r;
      end
   end

   // counter
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_r <= 8'h00;
         up_r    <= 1'b1;
         block_r <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (cnt_wr)
            block_r <= 1'b1;
         else if (tick)
            block_r <= 1'b0;
         if (cnt_wr)
            count_r <= AVS_WRITEDATA[7:0];
         else if (tick)
         begin
            if (pcor)
            begin
               if (up_r && at_top)
               begin
                  up_r    <= 1'b0;
                  count_r <= count_r - 8'h01;
               end
               else if (!up_r && count_r == VAL_BOTTOM)
               begin
                  up_r    <= 1'b1;
                  count_r <= count_r + 8'h01;
               end
               else
                  count_r <= up_r ? count_r + 8'h01 : count_r - 8'h01;
            end
            else
            begin
               up_r    <= 1'b1;
               count_r <= at_top ? VAL_BOTTOM : count_r + 8'h01;
            end
         end
      end
   end

   function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                      input logic hit, input logic frc,
                                      input logic [7:0] mval, input logic tgl_ok);
      logic ign;
      wave_next = cur;
      ign = pwm && act[1] && (mval == top);
      if (frc)
         wave_next = (act == ACT_TGL) ? !cur : (act == ACT_CLR) ? 1'b0 :
                     (act == ACT_SET) ? 1'b1 : cur;
      else if (!pwm && hit)
         wave_next = (act == ACT_TGL) ? !cur : (act == ACT_CLR) ? 1'b0 :
                     (act == ACT_SET) ? 1'b1 : cur;
      else if (act == ACT_TGL)
         wave_next = (tgl_ok && hit) ? !cur : cur;
      else if (fast && act[1])
      begin
         if (hit && !ign)
            wave_next = act[0];
         else if (tick && at_top)
            wave_next = !act[0];
      end
      else if (pcor && act[1])
      begin
         if (hit && !ign)
            wave_next = up_r ? act[0] : !act[0];
         else if (tick && at_top && ign)
            // level at top equals a down-counting match
            wave_next = !act[0];
      end
   endfunction

   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wave_a_r <= 1'b0;
         wave_b_r <= 1'b0;
      end
      else if (CLK_EN)
      begin
         wave_a_r <= wave_next(wave_a_r, act_a, hit_a, force_a, match_a_r, mode[2]);
         wave_b_r <= wave_next(wave_b_r, act_b, hit_b, force_b, match_b_r, 1'b0);
      end
   end

   // events: forced matches raise none
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ev_a_r  <= 1'b0;
         ev_b_r  <= 1'b0;
         ev_ov_r <= 1'b0;
      end
      else if (CLK_EN)
      begin
         ev_a_r  <= hit_a;
         ev_b_r  <= hit_b;
         ev_ov_r <= tick && (pcor ? (!up_r && count_r == 8'h01)
                  : (mode == EBT_FAST_A) ? at_top : (count_r == VAL_MAX));
      end
   end

   // pin muxing: port bits 0/1 data, 2/3 direction
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CHAN_A_WAVE_PIN_O    <= 1'b0;
         CHAN_B_WAVE_PIN_O    <= 1'b0;
         CHAN_A_WAVE_PIN_OE_N <= 1'b1;
         CHAN_B_WAVE_PIN_OE_N <= 1'b1;
      end
      else if (CLK_EN)
      begin
         CHAN_A_WAVE_PIN_O    <= conn_a ? wave_a_r : port_r[0];
         CHAN_B_WAVE_PIN_O    <= (act_b != ACT_OFF) ? wave_b_r : port_r[1];
         CHAN_A_WAVE_PIN_OE_N <= !port_r[2];
         CHAN_B_WAVE_PIN_OE_N <= !port_r[3];
      end
   end

   assign MATCH_A_EVENT  = ev_a_r;
   assign MATCH_B_EVENT  = ev_b_r;
   assign OVERFLOW_EVENT = ev_ov_r;

   // read path, one wait cycle
   always_ff @(posedge CLOCK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_done_r    <= 1'b0;
         AVS_READDATA <= 32'h0000_0000;
      end
      else if (CLK_EN)
      begin
         rd_done_r <= AVS_READ && !rd_done_r;
         if (AVS_READ && !rd_done_r)
         begin
            case (AVS_ADDRESS)
               {1'b0, OFS_CTRL_A}:  AVS_READDATA <= {24'h0, ctrl_a_r};
               {1'b0, OFS_CTRL_B}:  AVS_READDATA <= {24'h0, ctrl_b_r};
               {1'b0, OFS_COUNT}:   AVS_READDATA <= {24'h0, count_r};
               {1'b0, OFS_MATCH_A}: AVS_READDATA <= {24'h0, buf_a_r};
               OFS_MATCH_B:         AVS_READDATA <= {24'h0, buf_b_r};
               OFS_PORT:            AVS_READDATA <= {28'h0, port_r};
               OFS_FLAGS:           AVS_READDATA <= {29'h0, up_r, wave_b_r, wave_a_r};
               default:             AVS_READDATA <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign AVS_WAITREQUEST = AVS_READ && !rd_done_r;

   AST_FORCE_NO_EVENT: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (force_a && !hit_a) |=> !ev_a_r)
      else $error("forced match raised event");
   AST_STOPPED: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && ctrl_b_r[2:0] == 3'h0 && !cnt_wr) |=> $stable(count_r))
      else $error("counter moved while stopped");
   AST_BLOCK: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && cnt_wr) |=> !hit_a && !hit_b)
      else $error("match after counter write");
   AST_PIN_DIR: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && !port_r[3]) |=> CHAN_B_WAVE_PIN_OE_N)
      else $error("pin driven as input");
   AST_CTRL_ZERO: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (ctrl_a_r[3:2] == 2'b00) && (ctrl_b_r[7:4] == 4'h0))
      else $error("reserved control bits set");
   AST_PC_TOP: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && tick && pcor && up_r && at_top && !cnt_wr) |=> !up_r)
      else $error("phase correct did not reverse");
   AST_DIV8: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && tick && ctrl_b_r[2:0] == 3'h2
       && !(wr && sel(AVS_ADDRESS, {1'b0, OFS_CTRL_B}))) |=> !tick)
      else $error("prescaler tick too soon");
   AST_FAST_TOP: assert property (@(posedge CLOCK) disable iff (!rst_n)
      (CLK_EN && tick && fast && act_b == ACT_CLR && at_top && !hit_b && !force_b)
      |=> wave_b_r)
      else $error("fast pwm not set at top");
endmodule // ebt_timer
`default_nettype wire

// File: tb/ebt_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ebt_pkg::*;
   localparam logic [4:0] RA = 5'(OFS_CTRL_A);
   localparam logic [4:0] RB = 5'(OFS_CTRL_B);
   localparam logic [4:0] RC = 5'(OFS_COUNT);
   localparam logic [4:0] RM = 5'(OFS_MATCH_A);
   localparam logic [4:0] RN = OFS_MATCH_B;
   localparam logic [4:0] RP = OFS_PORT;
   logic        CLOCK;
   logic        RST_N;
   logic        CLK_EN;
   logic [4:0]  AVS_ADDRESS;
   logic        AVS_READ;
   logic        AVS_WRITE;
   logic [31:0] AVS_WRITEDATA;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic        pa_o, pa_oe_n, pb_o, pb_oe_n, ev_a, ev_b, ev_ov;
   logic        wait_s;
   logic [7:0]  rd_s;
   logic [7:0]  q;
   int          mismatches, comparisons, cyc, nb;
   int          divs [7] = '{1, 8, 32, 64, 128, 256, 1024};
   logic [1:0]  acts [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
   logic        lvls [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   ebt_timer dut_u
   (
      .CLOCK                (CLOCK),
      .RST_N                (RST_N),
      .CLK_EN               (CLK_EN),
      .AVS_ADDRESS          (AVS_ADDRESS),
      .AVS_READ             (AVS_READ),
      .AVS_WRITE            (AVS_WRITE),
      .AVS_WRITEDATA        (AVS_WRITEDATA),
      .AVS_BYTEENABLE       (4'h1),
      .AVS_READDATA         (AVS_READDATA),
      .AVS_WAITREQUEST      (AVS_WAITREQUEST),
      .CHAN_A_WAVE_PIN_O    (pa_o),
      .CHAN_A_WAVE_PIN_OE_N (pa_oe_n),
      .CHAN_B_WAVE_PIN_O    (pb_o),
      .CHAN_B_WAVE_PIN_OE_N (pb_oe_n),
      .MATCH_A_EVENT        (ev_a),
      .MATCH_B_EVENT        (ev_b),
      .OVERFLOW_EVENT       (ev_ov)
   );

   initial
   begin
      CLOCK = 1'b0;
      forever #10 CLOCK = ~CLOCK;
   end

   // mid-cycle copies equal what the next rising edge samples
   always @(negedge CLOCK)
   begin
      wait_s = AVS_WAITREQUEST;
      rd_s = AVS_READDATA[7:0];
      if (ev_b === 1'b1)
         nb = nb + 1;
   end

   always @(posedge CLOCK)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         mismatches = mismatches + 1;
         final_report;
      end
   end

   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons = comparisons + 1;
      if (g !== e)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task test_done(input string nm);
      $display("test %s done", nm);
   endtask

   // one access; request held until waitrequest is seen low
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      AVS_ADDRESS <= a;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_WRITEDATA <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (wait_s !== 1'b0 && n < 20);
      q = rd_s;
      chk("waitrequest", 0, wait_s);
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge CLOCK);
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, q);
   endtask

   task pins(input logic eoe, input logic eo);
      @(negedge CLOCK);
      chk("oe_n_b", eoe, pb_oe_n);
      chk("pin_b", eo, pb_o);
      @(posedge CLOCK);
   endtask

   // cycles between events, and pin b high cycles in that span
   task period(input int e, input int he, input logic ov);
      int n, h, k;
      for (k = 0; k < 3; k++)
      begin
         n = 0;
         h = 0;
         do
         begin
            @(negedge CLOCK);
            n++;
            h += (pb_o === 1'b1);
         end
         while (((ov ? ev_ov : ev_a) !== 1'b1) && n < 5000);
      end
      chk("period", e, n);
      if (he >= 0)
         chk("high", he, h);
      @(posedge CLOCK);
   endtask

   initial
   begin
      logic [4:0] adr [6];
      adr = '{RA, RB, RC, RM, RN, 5'h1c};
      RST_N = 1'b0;
      CLK_EN = 1'b1;
      AVS_ADDRESS = 5'h00;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = 32'h0;
      mismatches = 0;
      comparisons = 0;
      cyc = 0;
      nb = 0;
      repeat (8) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLOCK);
      chk("oe_n_a", 1, pa_oe_n);
      pins(1'b1, 1'b0);
      for (int i = 0; i < 6; i++)
         rd_chk("reset", adr[i], 8'h00);
      test_done("reset");
      wr(RA, 8'hff);
      wr(RB, 8'h3f);
      rd_chk("ctrl_a", RA, CTRL_A_MASK);
      rd_chk("ctrl_b", RB, CTRL_B_MASK);
      wr(5'h1c, 8'h55);
      rd_chk("unmapped", 5'h1c, 8'h00);
      wr(RB, 8'h00);
      wr(RA, 8'h00);
      wr(RC, 8'h5a);
      repeat (20) @(posedge CLOCK);
      rd_chk("count", RC, 8'h5a);
      test_done("registers");
      wr(RP, 8'h02);
      pins(1'b1, 1'b1);
      wr(RP, 8'h08);
      wr(RM, 8'h10);
      wr(RN, 8'h80);
      wr(RA, 8'h02);
      wr(RB, 8'h01);
      pins(1'b0, 1'b0);
      for (int k = 0; k < 4; k++)
      begin
         wr(RA, {2'b00, acts[k], 4'b0010});
         wr(RB, 8'h41);
         rd_chk("ctrl_b", RB, 8'h01);
         pins(1'b0, lvls[k]);
      end
      wr(RP, 8'h0a);
      pins(1'b0, 1'b0);
      chk("match_b_events", 0, nb);
      test_done("force");
      wr(RM, 8'h03);
      for (int s = 1; s < 8; s++)
      begin
         wr(RB, 8'(s));
         period(4 * divs[s - 1], -1, 1'b0);
      end
      test_done("prescale");
      wr(RN, 8'h40);
      wr(RA, 8'h23);
      wr(RB, 8'h01);
      period(256, 65, 1'b1);
      wr(RA, 8'h33);
      period(256, 191, 1'b1);
      wr(RA, 8'h23);
      wr(RN, 8'hff);
      period(256, 256, 1'b1);
      wr(RA, 8'h01);
      period(510, -1, 1'b1);
      wr(RM, 8'h63);
      wr(RA, 8'h03);
      wr(RB, 8'h09);
      period(100, -1, 1'b1);
      wr(RA, 8'h01);
      period(198, -1, 1'b1);
      wr(RB, 8'h01);
      wr(RA, 8'h21);
      wr(RN, 8'h40);
      period(510, 128, 1'b1);
      wr(RN, 8'hff);
      period(510, 510, 1'b1);
      test_done("pwm");
      wr(RA, 8'h00);
      wr(RC, 8'h20);
      CLK_EN <= 1'b0;
      repeat (10) @(posedge CLOCK);
      CLK_EN <= 1'b1;
      rd_chk("freeze", RC, 8'h21);
      wr(RP, 8'h01);
      wr(RA, 8'h43);
      @(negedge CLOCK);
      chk("pin_a", 1, pa_o);
      @(posedge CLOCK);
      test_done("freeze");
      final_report;
   end
endmodule // testbench
`default_nettype wire
